// >>> logic/fcd_pkg.sv
package fcd_pkg;
  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_READ_ID   = 8'h9f;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_RD_CONFIG = 8'h15;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_RD_CFG2   = 8'h71;
  localparam logic [7:0] OP_WR_CFG2   = 8'h72;
  localparam logic [7:0] OP_RD_SECUR  = 8'h2b;
  localparam logic [7:0] OP_WR_SECUR  = 8'h2f;
  localparam logic [7:0] OP_READ3     = 8'h03;
  localparam logic [7:0] OP_READ4     = 8'h13;
  localparam logic [7:0] OP_QREAD3    = 8'h0b;
  localparam logic [7:0] OP_QREAD4    = 8'h0c;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD      = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD      = 8'h04;
  // ------------------------------------------------------------
  // bit counts within a frame
  // ------------------------------------------------------------
  localparam logic [6:0] CNT_OP    = 7'h08;
  localparam logic [6:0] CNT_SR1   = 7'h10;
  localparam logic [6:0] CNT_SR2   = 7'h18;
  localparam logic [6:0] CNT_A3    = 7'h20;
  localparam logic [6:0] CNT_A4    = 7'h28;
  localparam logic [6:0] CNT_Q4    = 7'h30;
  localparam logic [6:0] CNT_SAT   = 7'h7f;
  localparam logic [6:0] CNT_WRAP  = 7'h78;
  // ------------------------------------------------------------
  // register layout and reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  SR_WMASK     = 8'hfc;
  localparam logic [7:0]  SR_RST       = 8'h00;
  localparam logic [7:0]  CR_RST       = 8'h00;
  localparam logic [63:0] CR2_RST      = 64'h0;
  localparam int          SCUR_LOCK    = 1;
  localparam logic [31:0] CR2_CRC_ADDR = 32'h0000_0040;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int STATUS_WRITE_TIME_NS = 40000;
  localparam int MCLK_PERIOD_NS       = 20;
  localparam int TW_CYCLES = (STATUS_WRITE_TIME_NS + MCLK_PERIOD_NS - 1)
                             / MCLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0]  sr;
    logic [7:0]  cr;
    logic [7:0]  scur;
    logic [63:0] cr2;
    logic        crc;
    logic        pe_busy;
    logic        write_in_progress;
  } fcd_regs_t;

  typedef enum logic {WC_IDLE = 1'b0, WC_BUSY = 1'b1} fcd_wc_t;
endpackage

// >>> logic/fcd_core.sv
`timescale 1ns/1ns
// Functional notes
// RULE1 - id read shifts maker byte, then type, density
// RULE2 - host may end id read anytime
// RULE3 - id opcode ignored during program or erase
// RULE4 - status read accepted at any time
// RULE5 - host polls write-in-progress before new commands
// RULE6 - config read accepted at any time
// RULE7 - host sets write-enable before status write
// RULE8 - status write keeps latch and busy bits
// RULE9 - status write needs 8/16 data bit boundary
// RULE10 - write cycle holds busy, then clears latch
// RULE11 - config2 read rejected while busy, except crc
// RULE12 - config2 read: opcode, four address bytes, data
// RULE13 - host sets write-enable before config2 write
// RULE14 - config2 write bad boundary clears latch
// RULE15 - security read any time, repeats continuously
// RULE16 - security write sets otp lock, then frozen
// RULE17 - security write needs exact command boundary
// RULE18 - address sampled rising, data driven falling
// RULE19 - read address increments per byte, wraps
// RULE20 - host sends 24 or 32 address bits
// RULE21 - quick read inserts eight dummy clocks
// RULE22 - quick read rejected while busy
// RULE23 - write-enable sets latch for writes
// RULE24 - writes ignored while latch clear
module fcd_core
  import fcd_pkg::*;
#(
  parameter int         ADDR_W    = 26,
  parameter int         TW_CYC    = TW_CYCLES,
  parameter logic [7:0] MAKER_ID  = 8'h5a, // arbitrary value
  parameter logic [7:0] TYPE_ID   = 8'h21, // arbitrary value
  parameter logic [7:0] DENS_ID   = 8'h1a, // arbitrary value
  parameter logic       LOCK_RST  = 1'b0
) (
  input  wire logic              MCLK,
  input  wire logic              ARST_N,
  input  wire logic              SCLK,
  input  wire logic              CS_N,
  input  wire logic              SI,
  output logic                   SO,
  output logic                   SO_OE,
  output logic [ADDR_W-1:0]      ARR_ADDR,
  input  wire logic [7:0]        ARR_RDATA,
  input  wire logic              PGM_ERS_BUSY,
  input  wire logic              CRC_ERR,
  input  wire logic [7:0]        SCUR_IN,
  output logic [7:0]             STATUS_Q,
  output logic [7:0]             CONFIG_Q,
  output logic                   OTP_LOCKED,
  output logic                   WRITE_IN_PROGRESS
);
  generate
    if (ADDR_W < 16 || ADDR_W > 32 || TW_CYC < 1 || TW_CYC > 65535) begin
      $error("fcd_core: unsupported parameter value");
    end
  endgenerate

  // ------------------------------------------------------------
  // link side: shifting on the serial clock
  // ------------------------------------------------------------
  // chip select high clears only the frame flag and the serial output; count and opcode are kept; no edge is counted on
  // after a frame, so the frame flag is cleared by select itself
  wire frm_rst_n = ARST_N & ~CS_N;

  logic        started_ff, tog_ff;
  logic [6:0]  cnt_ff;
  logic [31:0] in_sr_ff, addr_ff;
  logic [7:0]  op_ff;
  logic [1:0]  id_idx_ff;
  logic        so_ff, so_oe_ff;
  fcd_regs_t   rs1_ff, rs2_ff, regs_ff;

  wire [6:0]  nxt_cnt = !started_ff ? 7'h01 :
                        (cnt_ff == CNT_SAT) ? CNT_WRAP : cnt_ff + 7'h01;
  wire [31:0] nxt_sr  = {in_sr_ff[30:0], SI};
  wire        op_ok   = started_ff && cnt_ff >= CNT_OP;
  wire        qread   = op_ff == OP_QREAD3 || op_ff == OP_QREAD4;
  wire        aread   = qread || op_ff == OP_READ3 || op_ff == OP_READ4;
  wire        addr3   = op_ff == OP_READ3 || op_ff == OP_QREAD3; // RULE20
  wire [6:0]  a_end   = addr3 ? CNT_A3 : CNT_A4;
  wire [6:0]  start   = op_ff == OP_READ3 ? CNT_A3 :
                        op_ff == OP_QREAD4 ? CNT_Q4 : // RULE21
                        (op_ff == OP_READ4 || op_ff == OP_QREAD3 ||
                         op_ff == OP_RD_CFG2) ? CNT_A4 : CNT_OP; // RULE12
  wire        is_read = aread || op_ff == OP_READ_ID ||
                        op_ff == OP_RD_STATUS || op_ff == OP_RD_CONFIG ||
                        op_ff == OP_RD_SECUR || op_ff == OP_RD_CFG2;
  wire        crc_adr = addr_ff == CR2_CRC_ADDR;
  wire        rej     = (op_ff == OP_READ_ID && rs2_ff.pe_busy) || // RULE3
                        (qread && rs2_ff.write_in_progress) || // RULE22
                        (op_ff == OP_RD_CFG2 && rs2_ff.write_in_progress &&
                         !crc_adr); // RULE11
  wire        data_on = op_ok && is_read && !rej && cnt_ff >= start;
  wire        byte_nx = data_on && nxt_cnt[2:0] == 3'h0;
  wire [7:0]  id_byte = id_idx_ff == 2'h0 ? MAKER_ID :
                        id_idx_ff == 2'h1 ? TYPE_ID : DENS_ID; // RULE1
  wire [7:0]  cr2_byt = crc_adr ? {7'h00, rs2_ff.crc} :
                        addr_ff[31:3] == 29'h0 ?
                        rs2_ff.cr2[addr_ff[2:0]*8 +: 8] : 8'h00;
  wire [7:0]  cur_byte = op_ff == OP_READ_ID   ? id_byte :
                         op_ff == OP_RD_STATUS ? rs2_ff.sr : // RULE4
                         op_ff == OP_RD_CONFIG ? rs2_ff.cr : // RULE6
                         op_ff == OP_RD_SECUR  ? rs2_ff.scur : // RULE15
                         op_ff == OP_RD_CFG2   ? cr2_byt : ARR_RDATA;
  wire [ADDR_W-1:0] adr_inc = addr_ff[ADDR_W-1:0] + 1'b1;
  wire [31:0] nxt_addr = nxt_cnt == a_end && op_ok ?
                         (addr3 ? {8'h00, nxt_sr[23:0]} : nxt_sr) :
                         (byte_nx && aread) ? 32'(adr_inc) : // RULE19
                         addr_ff;
  wire [1:0]  nxt_idx = nxt_cnt == CNT_OP ? 2'h0 :
                        !byte_nx ? id_idx_ff :
                        id_idx_ff == 2'h2 ? 2'h0 : id_idx_ff + 2'h1;

  always_ff @(posedge SCLK or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      started_ff <= 1'b0;
    end else begin
      started_ff <= 1'b1;
    end
  end

  // address and opcode bits are taken on the rising edge
  always_ff @(posedge SCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tog_ff    <= 1'b0;
      cnt_ff    <= 7'h00;
      in_sr_ff  <= 32'h0;
      op_ff     <= 8'h00;
      addr_ff   <= 32'h0;
      id_idx_ff <= 2'h0;
      rs1_ff    <= '0;
      rs2_ff    <= '0;
    end else begin
      tog_ff    <= tog_ff ^ !started_ff;
      cnt_ff    <= nxt_cnt;
      in_sr_ff  <= nxt_sr; // RULE18
      op_ff     <= nxt_cnt == CNT_OP ? nxt_sr[7:0] : op_ff;
      addr_ff   <= nxt_addr;
      id_idx_ff <= nxt_idx;
      rs1_ff    <= regs_ff;
      rs2_ff    <= rs1_ff;
    end
  end

  // data leaves on the falling edge; select high drops the driver
  always_ff @(negedge SCLK or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      so_ff    <= 1'b0;
      so_oe_ff <= 1'b0; // RULE2
    end else begin
      so_ff    <= cur_byte[~cnt_ff[2:0]]; // RULE18
      so_oe_ff <= data_on;
    end
  end

  assign SO       = so_ff;
  assign SO_OE    = so_oe_ff;
  assign ARR_ADDR = addr_ff[ADDR_W-1:0];

  // ------------------------------------------------------------
  // core side: frame end, register writes and write cycle
  // ------------------------------------------------------------
  // frame words are read only after select has risen, when the
  // serial clock is stopped and they are steady
  logic       csq1_ff, csq2_ff, csq3_ff, tq1_ff, tq2_ff, seen_ff;
  logic       wel_ff, lock_ff;
  logic [7:0] sr_ff, cr_ff, sr_q_ff;
  logic [63:0] cr2_ff;
  logic [15:0] tw_ff;
  fcd_wc_t    wc_ff, nxt_wc;

  wire cs_rise = csq2_ff & ~csq3_ff;
  wire frm_end = cs_rise & (tq2_ff != seen_ff);
  wire write_in_progress     = (wc_ff == WC_BUSY) | PGM_ERS_BUSY;
  wire len_sr  = cnt_ff == CNT_SR1 || cnt_ff == CNT_SR2; // RULE9
  wire ok_sr   = op_ff == OP_WR_STATUS && len_sr;
  wire ok_c2   = op_ff == OP_WR_CFG2 && cnt_ff == CNT_Q4; // RULE14
  wire ok_sc   = op_ff == OP_WR_SECUR && cnt_ff == CNT_OP; // RULE17
  wire can_wr  = wel_ff && !write_in_progress; // RULE24
  wire go_wr   = frm_end && can_wr && (ok_sr || ok_c2 || ok_sc);
  wire tw_done = wc_ff == WC_BUSY && tw_ff == 16'(TW_CYC - 1);
  wire set_wel = frm_end && op_ff == OP_WRITE_ENABLE_CMD && cnt_ff == CNT_OP;
  wire clr_wel = tw_done || (frm_end && ((op_ff == OP_WRITE_DISABLE_CMD &&
                 cnt_ff == CNT_OP) || (op_ff == OP_WR_CFG2 && !ok_c2)));
  wire [7:0] wsr = cnt_ff == CNT_SR1 ? in_sr_ff[7:0] : in_sr_ff[15:8];
  wire [7:0] nxt_sr_v = (sr_ff & ~SR_WMASK) | (wsr & SR_WMASK); // RULE8
  wire c2_hit = ok_c2 && addr_ff[31:3] == 29'h0;
  wire [63:0] c2_mask = 64'hff << {addr_ff[2:0], 3'h0};
  wire [63:0] nxt_c2 = (cr2_ff & ~c2_mask) |
                       ({8{in_sr_ff[7:0]}} & c2_mask);
  wire [7:0] scur = {SCUR_IN[7:2], lock_ff, SCUR_IN[0]};

  always_comb begin
    nxt_wc = wc_ff;
    case (wc_ff)
      WC_IDLE: begin
        if (go_wr) begin
          nxt_wc = WC_BUSY; // RULE10
        end
      end
      WC_BUSY: begin
        if (tw_done) begin
          nxt_wc = WC_IDLE;
        end
      end
      default: nxt_wc = WC_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      csq1_ff <= 1'b1;
      csq2_ff <= 1'b1;
      csq3_ff <= 1'b1;
      tq1_ff  <= 1'b0;
      tq2_ff  <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      csq1_ff <= CS_N;
      csq2_ff <= csq1_ff;
      csq3_ff <= csq2_ff;
      tq1_ff  <= tog_ff;
      tq2_ff  <= tq1_ff;
      seen_ff <= cs_rise ? tq2_ff : seen_ff;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wc_ff   <= WC_IDLE;
      tw_ff   <= 16'h0;
      wel_ff  <= 1'b0;
      lock_ff <= LOCK_RST;
      sr_ff   <= SR_RST;
      cr_ff   <= CR_RST;
      cr2_ff  <= CR2_RST;
    end else begin
      wc_ff   <= nxt_wc;
      tw_ff   <= wc_ff == WC_BUSY ? tw_ff + 16'h1 : 16'h0;
      wel_ff  <= set_wel | (wel_ff & ~clr_wel); // RULE23
      lock_ff <= lock_ff | (go_wr & ok_sc); // RULE16
      sr_ff   <= go_wr && ok_sr ? nxt_sr_v : sr_ff;
      cr_ff   <= go_wr && ok_sr && cnt_ff == CNT_SR2 ? in_sr_ff[7:0]
                                                     : cr_ff;
      cr2_ff  <= go_wr && c2_hit ? nxt_c2 : cr2_ff;
    end
  end

  // outputs and the snapshot sent to the link side
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sr_q_ff           <= SR_RST;
      CONFIG_Q          <= CR_RST;
      OTP_LOCKED        <= LOCK_RST;
      WRITE_IN_PROGRESS <= 1'b0;
      regs_ff           <= '0;
    end else begin
      sr_q_ff           <= {sr_ff[7:2], wel_ff, write_in_progress}; // RULE8
      CONFIG_Q          <= cr_ff;
      OTP_LOCKED        <= lock_ff;
      WRITE_IN_PROGRESS <= write_in_progress;
      // frozen while select is low so the serial side never takes a
      // torn word; needs two core clocks before the second serial edge
      if (csq2_ff) begin
        regs_ff <= '{sr: {sr_ff[7:2], wel_ff, write_in_progress}, cr: cr_ff,
                     scur: scur, cr2: cr2_ff, crc: CRC_ERR,
                     pe_busy: PGM_ERS_BUSY, write_in_progress: write_in_progress};
      end
    end
  end

  assign STATUS_Q = sr_q_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  sequence s_wr_start;
    go_wr ##1 (wc_ff == WC_BUSY);
  endsequence

  a_wip_holds: assert property (s_wr_start |-> write_in_progress [*8]) // RULE10
    else $error("write cycle dropped busy early");
  a_wel_cleared: assert property (tw_done && !set_wel |=> !wel_ff) // RULE10
    else $error("latch not cleared at cycle end");
  a_low_bits: assert property (##1 STATUS_Q[1] == $past(wel_ff) && // RULE8
                               STATUS_Q[0] == $past(write_in_progress))
    else $error("status low bits not hardware state");
  a_no_wel_wr: assert property (frm_end && !wel_ff |=> // RULE24
                                $stable(sr_ff) && wc_ff == WC_IDLE)
    else $error("write taken without latch");
  a_write_enable_cmd_sets: assert property (set_wel && !tw_done |=> wel_ff) // RULE23
    else $error("write enable did not set latch");
  a_sr_len: assert property (frm_end && !len_sr && // RULE9
                             op_ff == OP_WR_STATUS && wc_ff == WC_IDLE
                             |=> wc_ff == WC_IDLE)
    else $error("bad length status write accepted");
  a_cr2_bad: assert property (frm_end && op_ff == OP_WR_CFG2 && !ok_c2
                              && !set_wel |=> !wel_ff) // RULE14
    else $error("bad config2 write kept latch");
  a_lock_sticky: assert property (lock_ff |=> lock_ff [*2]) // RULE16
    else $error("otp lock released");
endmodule

// >>> testbench/fcd_host.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// host controller model, mode 0
// ------------------------------------------------------------
module fcd_host (
  output logic      SCLK,
  output logic      CS_N,
  output logic      SI,
  input  wire logic SO,
  input  wire logic SO_OE
);
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SI   = 1'b0;
  end

  // tx is msb aligned; clock stands low outside frames
  task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
                       output logic [63:0] rx, output logic oe);
    rx = '0;
    oe = 1'b0;
    #3 CS_N = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      // after the command the line is left toggling, never stale
      SI = (i < ntx) ? tx[63-i] : ~SI;
      #40 SCLK = 1'b1;
      if (i >= ntx) begin
        // a released line reads inverted, so stale data is caught
        rx = {rx[62:0], SO_OE ? SO : ~SO};
        oe = oe | SO_OE;
      end
      #40 SCLK = 1'b0;
    end
    #20 CS_N = 1'b1;
    SI = ~SI;
    // long gap so the core domain sees the frame end
    #200;
  endtask
endmodule

// >>> testbench/tb_flash_register_read_commands.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// testbench
// ------------------------------------------------------------
module tb_flash_register_read_commands;
  import fcd_pkg::*;
  localparam int AW = 16;
  localparam int TW = 200;
  logic          mclk = 1'b0;
  logic          arst_n, sclk, cs_n, si, so, so_oe, busy, crc;
  logic          otp, write_in_progress;
  logic [AW-1:0] arr_addr;
  logic [7:0]    scur, st_q, cf_q;
  logic [63:0]   rx;
  logic          oe;
  int            err_total = 0;
  int            n_checks = 0;

  always #10 mclk = ~mclk;

  fcd_host host (.SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe));

  fcd_core #(.ADDR_W(AW), .TW_CYC(TW)) uut (
    .MCLK(mclk), .ARST_N(arst_n), .SCLK(sclk), .CS_N(cs_n), .SI(si),
    .SO(so), .SO_OE(so_oe), .ARR_ADDR(arr_addr),
    .ARR_RDATA(arr_addr[7:0] ^ 8'h96), .PGM_ERS_BUSY(busy), .CRC_ERR(crc),
    .SCUR_IN(scur), .STATUS_Q(st_q), .CONFIG_Q(cf_q),
    .OTP_LOCKED(otp), .WRITE_IN_PROGRESS(write_in_progress));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic fr(input logic [63:0] tx, input int ntx, input int nrx);
    host.frame(tx, ntx, nrx, rx, oe);
  endtask

  task automatic write_enable_cmd();
    fr({OP_WRITE_ENABLE_CMD, 56'h0}, 8, 0);
  endtask

  // bounded poll of the busy flag, as a careful host would
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(negedge mclk);
    while (write_in_progress !== 1'b0) begin
      @(negedge mclk);
      n++;
      if (n > 400) begin
        err_total++;
        report_and_stop();
      end
    end
  endtask

  task automatic t_id();
    fr({OP_READ_ID, 56'h0}, 8, 24);
    chk("id", 24'h5a211a, rx[23:0]);
    fr({OP_READ_ID, 56'h0}, 8, 4);
    chk("id cut oe", 1'b0, so_oe);
  endtask

  task automatic t_busy();
    @(negedge mclk);
    busy = 1'b1;
    crc  = 1'b1;
    #200;
    fr({OP_READ_ID, 56'h0}, 8, 8);
    chk("id busy oe", 1'b0, oe);
    fr({OP_RD_STATUS, 56'h0}, 8, 8);
    chk("status busy", 8'h01, rx[7:0]);
    fr({OP_RD_CONFIG, 56'h0}, 8, 8);
    chk("config busy", 9'h100, {oe, rx[7:0]});
    fr({OP_RD_SECUR, 56'h0}, 8, 16);
    chk("secur busy", 16'ha5a5, rx[15:0]);
    fr({OP_QREAD3, 56'h0}, 40, 8);
    chk("qread busy oe", 1'b0, oe);
    fr({OP_RD_CFG2, 56'h0}, 40, 8);
    chk("cfg2 busy oe", 1'b0, oe);
    fr({OP_RD_CFG2, 32'h40, 24'h0}, 40, 8);
    chk("crc busy", 8'h01, rx[7:0]);
    @(negedge mclk);
    busy = 1'b0;
    wait_idle();
  endtask

  task automatic t_status();
    fr({OP_WR_STATUS, 8'hfc, 48'h0}, 16, 0);
    chk("status no latch", 8'h00, st_q);
    write_enable_cmd();
    chk("latch set", 8'h02, st_q);
    fr({OP_WR_STATUS, 8'hff, 48'h0}, 12, 0);
    chk("status bad edge", 8'h02, st_q);
    fr({OP_WR_STATUS, 8'hff, 48'h0}, 16, 0);
    chk("wip held", 1'b1, write_in_progress);
    fr({OP_RD_STATUS, 56'h0}, 8, 8);
    chk("status in write", 8'hff, rx[7:0]);
    wait_idle();
    chk("status done", 8'hfc, st_q);
    write_enable_cmd();
    fr({OP_WR_STATUS, 8'h00, 8'ha5, 40'h0}, 24, 0);
    wait_idle();
    chk("config write", 16'ha500, {cf_q, st_q});
    fr({OP_RD_CONFIG, 56'h0}, 8, 8);
    chk("config read", 8'ha5, rx[7:0]);
  endtask

  task automatic t_cfg2();
    write_enable_cmd();
    fr({OP_WR_CFG2, 32'h3, 8'h3c, 16'h0}, 48, 0);
    wait_idle();
    fr({OP_RD_CFG2, 32'h3, 24'h0}, 40, 8);
    chk("cfg2 read", 8'h3c, rx[7:0]);
    write_enable_cmd();
    fr({OP_WR_CFG2, 32'h3, 8'h00, 16'h0}, 44, 0);
    chk("cfg2 bad edge", 8'h00, st_q);
  endtask

  task automatic t_secur();
    fr({OP_WR_SECUR, 56'h0}, 8, 0);
    chk("lock no latch", 1'b0, otp);
    write_enable_cmd();
    fr({OP_WRITE_DISABLE_CMD, 56'h0}, 8, 0);
    chk("latch cleared", 8'h00, st_q);
    fr({OP_WR_SECUR, 56'h0}, 8, 0);
    chk("lock after clear", 1'b0, otp);
    write_enable_cmd();
    fr({OP_WR_SECUR, 56'h0}, 9, 0);
    chk("lock bad edge", 1'b0, otp);
    write_enable_cmd();
    fr({OP_WR_SECUR, 56'h0}, 8, 0);
    wait_idle();
    chk("lock set", 1'b1, otp);
    fr({OP_RD_SECUR, 56'h0}, 8, 8);
    chk("secur locked", 8'ha7, rx[7:0]);
  endtask

  // all four array reads from one below the top address, across the wrap
  task automatic t_array();
    logic [7:0] ops [4] = '{OP_READ3, OP_READ4, OP_QREAD3, OP_QREAD4};
    int         ab [4]  = '{24, 32, 24, 32};
    int         dm [4]  = '{0, 0, 8, 8};
    for (int k = 0; k < 4; k++) begin
      fr({ops[k], 56'h0} | (64'hfffe << (56 - ab[k])), 8 + ab[k] + dm[k], 24);
      chk("array", {8'hfe ^ 8'h96, 8'hff ^ 8'h96, 8'h96},
          rx[23:0]);
    end
  endtask

  initial begin
    arst_n = 1'b0;
    busy   = 1'b0;
    crc    = 1'b0;
    scur   = 8'ha5;
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    repeat (3) @(negedge mclk);
    #7;
    t_id();
    t_busy();
    t_status();
    t_cfg2();
    t_secur();
    t_array();
    report_and_stop();
  end
endmodule
